// File: hw/psrc_pkg.sv
/*
 * Shared constants for the PLL scan reconfiguration controller: selector
 * encodings, the cached scan-chain layout, timing figures and field lookups.
 * Assumes a single 40 MHz system clock; the chain layout must be matched to
 * the target PLL before use.
 */
package psrc_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 25;
	// least hold of the pll reset pulse, rounded up
	localparam int RESET_HOLD_NS = 100;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest wait for scan-complete, rounded down
	localparam int SCANDONE_TIMEOUT_NS = 100000;
	localparam int SCANDONE_TIMEOUT_CYC = SCANDONE_TIMEOUT_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// divider select codes
	// ****************************************************************
	localparam logic [3:0] DIV_N = 4'h0;
	localparam logic [3:0] DIV_M = 4'h1;
	localparam logic [3:0] DIV_CPLF = 4'h2;
	localparam logic [3:0] DIV_VCO = 4'h3;
	localparam logic [3:0] DIV_C0 = 4'h4;
	localparam logic [3:0] DIV_C4 = 4'h8;

	// ****************************************************************
	// field select codes
	// ****************************************************************
	localparam logic [2:0] FLD_HIGH = 3'h0;
	localparam logic [2:0] FLD_LOW = 3'h1;
	localparam logic [2:0] FLD_BYP = 3'h4;
	localparam logic [2:0] FLD_ODD = 3'h5;
	localparam logic [2:0] FLD_NOM = 3'h7;
	localparam logic [2:0] FLD_CP_CUR = 3'h0;
	localparam logic [2:0] FLD_LF_RES = 3'h1;
	localparam logic [2:0] FLD_LF_CAP = 3'h2;
	localparam logic [2:0] FLD_LF_UNUSED = 3'h4;
	localparam logic [2:0] FLD_CP_UNUSED = 3'h5;
	localparam logic [2:0] FLD_VCO_POST = 3'h0;

	// ****************************************************************
	// cache layout, bit 0 shifted last
	// ****************************************************************
	localparam int CNT_BITS = 18;
	localparam int BASE_N = 0;
	localparam int BASE_M = 18;
	localparam int BASE_CPLF = 36;
	localparam int BASE_VCO = 52;
	localparam int BASE_C0 = 53;
	localparam int CHAIN_LEN = 143;
	localparam int OFS_HIGH = 10;
	localparam int OFS_LOW = 2;
	localparam int OFS_BYP = 1;
	localparam int OFS_ODD = 0;
	localparam int OFS_CP_UNUSED = 11;
	localparam int OFS_CP_CUR = 8;
	localparam int OFS_LF_UNUSED = 7;
	localparam int OFS_LF_RES = 2;
	localparam int OFS_LF_CAP = 0;
	localparam int DATA_W = 9;

	function automatic logic isCounter(input logic [3:0] d);
		return (d == DIV_N) || (d == DIV_M) || ((d >= DIV_C0) && (d <= DIV_C4));
	endfunction

	function automatic int cntBase(input logic [3:0] d);
		if (d == DIV_N)
			return BASE_N;
		if (d == DIV_M)
			return BASE_M;
		return BASE_C0 + CNT_BITS * (int'(d) - int'(DIV_C0));
	endfunction

	// zero width marks an illegal selector pair
	function automatic int fieldWidth(input logic [3:0] d, input logic [2:0] f);
		if (isCounter(d))
		begin
			case (f)
				FLD_HIGH, FLD_LOW: return 8;
				FLD_BYP, FLD_ODD: return 1;
				FLD_NOM: return 9;
				default: return 0;
			endcase
		end
		if (d == DIV_CPLF)
		begin
			case (f)
				FLD_CP_CUR: return 3;
				FLD_LF_RES: return 5;
				FLD_LF_CAP: return 2;
				FLD_LF_UNUSED: return 1;
				FLD_CP_UNUSED: return 5;
				default: return 0;
			endcase
		end
		if ((d == DIV_VCO) && (f == FLD_VCO_POST))
			return 1;
		return 0;
	endfunction

	function automatic int fieldLsb(input logic [3:0] d, input logic [2:0] f);
		if (isCounter(d))
		begin
			case (f)
				FLD_HIGH: return cntBase(d) + OFS_HIGH;
				FLD_LOW: return cntBase(d) + OFS_LOW;
				FLD_BYP: return cntBase(d) + OFS_BYP;
				FLD_ODD: return cntBase(d) + OFS_ODD;
				default: return cntBase(d);
			endcase
		end
		if (d == DIV_CPLF)
		begin
			case (f)
				FLD_CP_CUR: return BASE_CPLF + OFS_CP_CUR;
				FLD_LF_RES: return BASE_CPLF + OFS_LF_RES;
				FLD_LF_UNUSED: return BASE_CPLF + OFS_LF_UNUSED;
				FLD_CP_UNUSED: return BASE_CPLF + OFS_CP_UNUSED;
				default: return BASE_CPLF + OFS_LF_CAP;
			endcase
		end
		return BASE_VCO;
	endfunction

endpackage

// File: hw/psrc_nom_split.sv
/*
 * Splits a nominal divide count into high, low, odd and bypass fields.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module psrc_nom_split
(
	input wire logic [8:0] count,
	output logic [7:0] highCount,
	output logic [7:0] lowCount,
	output logic oddDiv,
	output logic bypass
);

	logic [9:0] sumUp;
	logic [8:0] highWide;
	logic [8:0] lowWide;

	always_comb
	begin
		// odd counts put the extra half period in the high phase
		sumUp = {1'b0, count} + 10'h001;
		highWide = sumUp[9:1];
		lowWide = count - highWide;
		// only a count of 511 overflows the 8-bit high phase field
		highCount = highWide[7:0];
		lowCount = lowWide[7:0];
		oddDiv = count[0];
		bypass = (count == 9'h001);
	end

endmodule
`default_nettype wire

// File: hw/psrc_core.sv
/*
 * PLL scan reconfiguration controller: cached scan-chain settings with
 * fetch/store/apply strobes, serial load of the PLL, config update and
 * PLL reset sequencing.
 * Assumes user strobes synchronous to sys_clk, one cycle long, and the PLL
 * scan ports wired directly to the pll* ports.
 */
`timescale 1ns/1ps
`default_nettype none
module psrc_core
	import psrc_pkg::*;
#(
	parameter logic [CHAIN_LEN-1:0] INIT_IMAGE = '0,
	parameter int HOLD_CYC = RESET_HOLD_CYC,
	parameter int TIMEOUT_CYC = SCANDONE_TIMEOUT_CYC
)
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic fetchStrobe,
	input wire logic storeStrobe,
	input wire logic applyStrobe,
	input wire logic [3:0] divSel,
	input wire logic [2:0] fieldSel,
	input wire logic [DATA_W-1:0] writeValue,
	output logic [DATA_W-1:0] readValue,
	output logic busy,
	input wire logic pllResetReq,
	input wire logic pllScanDone,
	input wire logic pllScanOut,
	output logic pllAreset,
	output logic pllConfigUpdate,
	output logic pllScanClk,
	output logic pllScanClkEna,
	output logic pllScanData,
	output logic scanOutBit,
	output logic scanDoneTimeout
);

	// ****************************************************************
	// state and registers
	// ****************************************************************
	typedef enum logic [2:0] {IDLE, FETCH, STORE, SHIFT, UPDATE, WAIT_DONE, PLL_RST, RELEASE}
		psrc_state_t;

	localparam int HOLD_W = (HOLD_CYC > 1) ? $clog2(HOLD_CYC) : 1;
	localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
	localparam logic [7:0] LAST_BIT = 8'(CHAIN_LEN - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);
	localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);

	psrc_state_t state;
	logic [CHAIN_LEN-1:0] cache;
	logic [3:0] selDiv;
	logic [2:0] selField;
	logic [DATA_W-1:0] wrData;
	logic [7:0] bitIdx;
	logic phase;
	logic [HOLD_W-1:0] holdCnt;
	logic [TMO_W-1:0] waitCnt;
	logic [CHAIN_LEN-1:0] wrMask;
	logic [CHAIN_LEN-1:0] wrVal;
	logic [DATA_W-1:0] rdVal;
	logic [7:0] nomHigh;
	logic [7:0] nomLow;
	logic nomOdd;
	logic nomByp;
	logic enterRst;
	logic holdActive;

	// a request is only looked at when idle, so strobes during busy vanish
	logic takeFetch;
	logic takeStore;
	logic takeApply;
	assign takeApply = (state == IDLE) && applyStrobe;
	assign takeStore = (state == IDLE) && !applyStrobe && storeStrobe;
	assign takeFetch = (state == IDLE) && !applyStrobe && !storeStrobe && fetchStrobe;

	psrc_nom_split u_split
	(
		.count(wrData),
		.highCount(nomHigh),
		.lowCount(nomLow),
		.oddDiv(nomOdd),
		.bypass(nomByp)
	);

	// ****************************************************************
	// write image and read selection
	// ****************************************************************
	always_comb
	begin
		int lsb;
		int w;
		int base;
		lsb = fieldLsb(selDiv, selField);
		w = fieldWidth(selDiv, selField);
		base = cntBase(selDiv);
		wrMask = '0;
		wrVal = '0;
		if ((selField == FLD_NOM) && isCounter(selDiv))
		begin
			for (int j = 0; j < 8; j++)
			begin
				wrMask[base + OFS_HIGH + j] = 1'b1;
				wrVal[base + OFS_HIGH + j] = nomHigh[j];
				wrMask[base + OFS_LOW + j] = 1'b1;
				wrVal[base + OFS_LOW + j] = nomLow[j];
			end
			wrMask[base + OFS_ODD] = 1'b1;
			wrVal[base + OFS_ODD] = nomOdd;
			wrMask[base + OFS_BYP] = 1'b1;
			wrVal[base + OFS_BYP] = nomByp;
		end
		else
		begin
			for (int j = 0; j < DATA_W; j++)
			begin
				if (j < w)
				begin
					wrMask[lsb + j] = 1'b1;
					wrVal[lsb + j] = wrData[j];
				end
			end
		end
	end

	always_comb
	begin
		int lsb;
		int w;
		int base;
		lsb = fieldLsb(selDiv, selField);
		w = fieldWidth(selDiv, selField);
		base = cntBase(selDiv);
		rdVal = '0;
		if ((selField == FLD_NOM) && isCounter(selDiv))
		begin
			if (cache[base + OFS_BYP])
				rdVal = 9'h001;
			else
				rdVal = {1'b0, cache[base + OFS_HIGH +: 8]} + {1'b0, cache[base + OFS_LOW +: 8]};
		end
		else
		begin
			for (int j = 0; j < DATA_W; j++)
			begin
				if (j < w)
					rdVal[j] = cache[lsb + j];
			end
		end
	end

	// ****************************************************************
	// cache storage, written only by a store
	// ****************************************************************
	for (genvar i = 0; i < CHAIN_LEN; i++)
	begin : g_cache
		always_ff @(posedge sys_clk)
		begin
			if (srst)
				cache[i] <= INIT_IMAGE[i];
			else if (ce && (state == STORE) && wrMask[i])
				cache[i] <= wrVal[i];
		end
	end

	// ****************************************************************
	// request capture
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			selDiv <= 4'h0;
			selField <= 3'h0;
			wrData <= '0;
		end
		else if (ce && (takeFetch || takeStore))
		begin
			// captured now, so later changes on the write value do nothing
			selDiv <= divSel;
			selField <= fieldSel;
			wrData <= writeValue;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			readValue <= '0;
		else if (ce && (state == FETCH))
			readValue <= rdVal;
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	assign enterRst = (state == WAIT_DONE) && (pllScanDone || (waitCnt == TMO_LAST));
	assign holdActive = (state == PLL_RST) && (holdCnt != HOLD_LAST);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= IDLE;
			busy <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state)
				IDLE:
				begin
					if (takeApply)
						state <= SHIFT;
					else if (takeStore)
						state <= STORE;
					else if (takeFetch)
						state <= FETCH;
					busy <= takeApply || takeStore || takeFetch;
				end
				FETCH, STORE:
				begin
					state <= IDLE;
					busy <= 1'b0;
				end
				SHIFT:
				begin
					if (phase && (bitIdx == 8'h00))
						state <= UPDATE;
				end
				UPDATE:
					state <= WAIT_DONE;
				WAIT_DONE:
				begin
					if (enterRst)
						state <= PLL_RST;
				end
				PLL_RST:
				begin
					if (!holdActive)
						state <= RELEASE;
				end
				RELEASE:
				begin
					state <= IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// scan shifter, msb of the cache first
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bitIdx <= 8'h00;
			phase <= 1'b0;
			pllScanClk <= 1'b0;
			pllScanClkEna <= 1'b0;
			pllScanData <= 1'b0;
			scanOutBit <= 1'b0;
		end
		else if (ce)
		begin
			if (takeApply)
			begin
				// full chain every time, whether or not anything changed
				bitIdx <= LAST_BIT;
				phase <= 1'b0;
				pllScanClkEna <= 1'b1;
				pllScanData <= cache[CHAIN_LEN-1];
			end
			else if (state == SHIFT)
			begin
				phase <= !phase;
				// scan clock is sys_clk halved, rising mid-bit
				pllScanClk <= !phase;
				if (phase)
				begin
					scanOutBit <= pllScanOut;
					if (bitIdx == 8'h00)
						pllScanClkEna <= 1'b0;
					else
					begin
						bitIdx <= bitIdx - 8'h01;
						pllScanData <= cache[bitIdx - 8'h01];
					end
				end
			end
			else
				pllScanData <= 1'b0;
		end
	end

	// ****************************************************************
	// update pulse, scan-complete wait and pll reset
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pllConfigUpdate <= 1'b0;
		else if (ce)
			pllConfigUpdate <= (state == SHIFT) && phase && (bitIdx == 8'h00);
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			waitCnt <= '0;
			scanDoneTimeout <= 1'b0;
		end
		else if (ce)
		begin
			if (takeApply)
			begin
				waitCnt <= '0;
				scanDoneTimeout <= 1'b0;
			end
			else if (state == WAIT_DONE)
			begin
				waitCnt <= waitCnt + TMO_W'(1);
				// a pll that never answers must not hang busy forever
				if ((waitCnt == TMO_LAST) && !pllScanDone)
					scanDoneTimeout <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			holdCnt <= '0;
		else if (ce)
		begin
			if (state == PLL_RST)
				holdCnt <= holdCnt + HOLD_W'(1);
			else
				holdCnt <= '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pllAreset <= 1'b0;
		else if (ce)
			pllAreset <= pllResetReq || enterRst || holdActive;
	end

endmodule
`default_nettype wire

// File: verif/psrc_core_props.sv
/*
 * Port-level checker for the PLL scan reconfiguration controller.
 * Assumes a single sys_clk domain with synchronous srst and ce held high.
 */
`timescale 1ns/1ps
`default_nettype none
module psrc_core_props
	import psrc_pkg::*;
#(
	parameter int HOLD_CYC = RESET_HOLD_CYC
)
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic fetchStrobe,
	input wire logic storeStrobe,
	input wire logic applyStrobe,
	input wire logic busy,
	input wire logic pllResetReq,
	input wire logic pllScanDone,
	input wire logic pllAreset,
	input wire logic pllConfigUpdate,
	input wire logic pllScanClk,
	input wire logic pllScanClkEna,
	input wire logic pllScanData
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	logic [7:0] holdCnt;

	always_ff @(posedge sys_clk)
	begin
		if (srst || !pllAreset)
			holdCnt <= 8'h00;
		else
			holdCnt <= holdCnt + 8'h01;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// ****************************************************************
	// properties
	// ****************************************************************
	a_busy_rise: assert property (ce && !busy && (fetchStrobe || storeStrobe || applyStrobe) |=> busy)
		else $error("busy did not rise after a strobe");
	a_busy_cause: assert property ($rose(busy) |-> $past(fetchStrobe || storeStrobe || applyStrobe))
		else $error("busy rose without a strobe");
	a_fetch_pulse: assert property (ce && !busy && fetchStrobe && !storeStrobe && !applyStrobe
		|=> busy ##1 !busy)
		else $error("fetch busy pulse wrong");
	a_req_areset: assert property (pllResetReq |=> pllAreset)
		else $error("reset request not forwarded");
	a_done_areset: assert property (busy && !pllScanClkEna && !pllConfigUpdate && $rose(pllScanDone)
		|=> pllAreset)
		else $error("no pll reset after scan done");
	a_areset_hold: assert property ($fell(pllAreset) && busy && !$past(srst) |-> holdCnt == HOLD_CYC)
		else $error("pll reset hold length wrong");
	a_busy_release: assert property ($fell(busy) && $past(busy, 2) && !$past(srst)
		|-> $past(pllAreset, 2) && !$past(pllAreset))
		else $error("busy fell without pll reset pulse");
	a_update_last: assert property ($fell(pllScanClkEna) && !$past(srst)
		|-> pllConfigUpdate ##1 !pllConfigUpdate)
		else $error("config update not pulsed after scan");
	a_clk_gated: assert property (!pllScanClkEna |-> !pllScanClk)
		else $error("scan clock outside enable");
	a_idle_quiet: assert property (!busy |-> !pllScanData && !pllScanClkEna)
		else $error("scan activity while idle");
endmodule
bind psrc_core psrc_core_props #(.HOLD_CYC(HOLD_CYC)) u_props (.sys_clk(sys_clk), .srst(srst),
	.ce(ce), .fetchStrobe(fetchStrobe), .storeStrobe(storeStrobe), .applyStrobe(applyStrobe),
	.busy(busy), .pllResetReq(pllResetReq), .pllScanDone(pllScanDone), .pllAreset(pllAreset),
	.pllConfigUpdate(pllConfigUpdate), .pllScanClk(pllScanClk), .pllScanClkEna(pllScanClkEna),
	.pllScanData(pllScanData));
`default_nettype wire

// File: verif/pll_scan_model.sv
/*
 * Behavioural PLL scan chain partner: captures shifted bits, answers scan done.
 * Assumes the scan clock is a registered copy of sys_clk activity.
 */
`timescale 1ns/1ps
`default_nettype none
module pll_scan_model
	import psrc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic scanClk,
	input wire logic scanClkEna,
	input wire logic scanData,
	input wire logic configUpdate,
	input wire logic silent,
	input wire logic slow,
	output logic scanDone,
	output logic scanOut,
	output logic [CHAIN_LEN-1:0] chain,
	output logic [8:0] bitCount
);
	logic prevClk;
	logic prevEna;
	logic [3:0] waitCnt;
	logic [1:0] doneCnt;

	always_ff @(posedge sys_clk)
	begin
		prevClk <= scanClk;
		prevEna <= scanClkEna;
		if (scanClkEna && !prevEna)
			bitCount <= 9'h000;
		else if (scanClkEna && scanClk && !prevClk)
		begin
			chain <= {chain[CHAIN_LEN-2:0], scanData};
			bitCount <= bitCount + 9'h001;
		end
		// released line toggles so stale values cannot pass
		scanOut <= scanClkEna ? chain[CHAIN_LEN-1] : ~scanOut;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			waitCnt <= 4'h0;
			doneCnt <= 2'h0;
			scanDone <= 1'b0;
		end
		else if (configUpdate && !silent)
			waitCnt <= slow ? 4'h8 : 4'h2;
		else if (waitCnt != 4'h0)
		begin
			waitCnt <= waitCnt - 4'h1;
			scanDone <= (waitCnt == 4'h1);
			doneCnt <= 2'h3;
		end
		else if (doneCnt != 2'h0)
			doneCnt <= doneCnt - 2'h1;
		else
			scanDone <= 1'b0;
	end
endmodule
`default_nettype wire

// File: verif/test_psrc_core.sv
/*
 * Self-checking bench for the PLL scan reconfiguration controller.
 * Assumes pll_scan_model on the scan side and a shortened reset hold.
 */
`timescale 1ns/1ps
`default_nettype none
module test_psrc_core
	import psrc_pkg::*;
;
	logic sys_clk, srst, ce, fetchStrobe, storeStrobe, applyStrobe, pllResetReq;
	logic silent, slow, busy, pllScanDone, pllScanOut, pllAreset, pllConfigUpdate;
	logic pllScanClk, pllScanClkEna, pllScanData, scanOutBit, scanDoneTimeout;
	logic [3:0] divSel;
	logic [2:0] fieldSel;
	logic [8:0] writeValue, readValue, got, bitCount;
	logic [CHAIN_LEN-1:0] chain;
	logic [8:0] expv [16][8] = '{default: '0};
	int fail_count = 0;
	int total_checks = 0;

	psrc_core #(.HOLD_CYC(2), .TIMEOUT_CYC(20)) DUT (.sys_clk(sys_clk), .srst(srst), .ce(ce),
		.fetchStrobe(fetchStrobe), .storeStrobe(storeStrobe), .applyStrobe(applyStrobe),
		.divSel(divSel), .fieldSel(fieldSel), .writeValue(writeValue), .readValue(readValue),
		.busy(busy), .pllResetReq(pllResetReq), .pllScanDone(pllScanDone),
		.pllScanOut(pllScanOut), .pllAreset(pllAreset), .pllConfigUpdate(pllConfigUpdate),
		.pllScanClk(pllScanClk), .pllScanClkEna(pllScanClkEna), .pllScanData(pllScanData),
		.scanOutBit(scanOutBit), .scanDoneTimeout(scanDoneTimeout));

	pll_scan_model u_pll (.sys_clk(sys_clk), .srst(srst), .scanClk(pllScanClk),
		.scanClkEna(pllScanClkEna), .scanData(pllScanData), .configUpdate(pllConfigUpdate),
		.silent(silent), .slow(slow), .scanDone(pllScanDone), .scanOut(pllScanOut),
		.chain(chain), .bitCount(bitCount));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		total_checks++;
		if (seen !== want)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 600; i++)
		begin
			@(posedge sys_clk);
			#1;
			if (!busy)
				return;
		end
		fail_count++;
		$display("CHECK FAILED at %0t: busy stuck", $time);
		wrap_up();
	endtask

	// kind 0 fetch, 1 store, 2 apply
	task automatic op(input int kind, input logic [3:0] d, input logic [2:0] f, input logic [8:0] v);
		@(posedge sys_clk);
		divSel <= d;
		fieldSel <= f;
		writeValue <= v;
		fetchStrobe <= (kind == 0);
		storeStrobe <= (kind == 1);
		applyStrobe <= (kind == 2);
		@(posedge sys_clk);
		fetchStrobe <= 1'b0;
		storeStrobe <= 1'b0;
		applyStrobe <= 1'b0;
		writeValue <= ~v;
		wait_idle();
		got = readValue;
	endtask

	function automatic int tw(input int d, input int f);
		if (d == 0 || d == 1 || (d >= 4 && d <= 8))
			return (f < 2) ? 8 : (f == 4 || f == 5) ? 1 : (f == 7) ? 9 : 0;
		if (d == 2)
			return (f == 0) ? 3 : (f == 1 || f == 5) ? 5 : (f == 2) ? 2 : (f == 4) ? 1 : 0;
		return (d == 3 && f == 0) ? 1 : 0;
	endfunction

	function automatic int lsb(input int d, input int f);
		if (d == 3)
			return BASE_VCO;
		if (d == 2)
			return BASE_CPLF + ((f == 0) ? OFS_CP_CUR : (f == 1) ? OFS_LF_RES :
				(f == 4) ? OFS_LF_UNUSED : (f == 5) ? OFS_CP_UNUSED : OFS_LF_CAP);
		return ((d == 0) ? BASE_N : (d == 1) ? BASE_M : BASE_C0 + CNT_BITS * (d - 4)) +
			((f == 0) ? OFS_HIGH : (f == 1) ? OFS_LOW : (f == 4) ? OFS_BYP : OFS_ODD);
	endfunction

	function automatic logic [CHAIN_LEN-1:0] want_chain();
		logic [CHAIN_LEN-1:0] c;
		c = '0;
		for (int d = 0; d < 16; d++)
			for (int f = 0; f < 7; f++)
				for (int k = 0; k < tw(d, f); k++)
					c[lsb(d, f) + k] = expv[d][f][k];
		return c;
	endfunction

	task automatic read_all();
		for (int d = 0; d < 16; d++)
			for (int f = 0; f < 8; f++)
				if (!(f == 7 && tw(d, f) > 0))
				begin
					op(0, d[3:0], f[2:0], 9'h000);
					check(got, (tw(d, f) == 0) ? 9'h000 : expv[d][f]);
				end
	endtask

	task automatic t_store_all();
		for (int d = 0; d < 16; d++)
			for (int f = 0; f < 7; f++)
				if (tw(d, f) > 0)
				begin
					op(1, d[3:0], f[2:0], 9'(d * 37 + f * 11 + 5));
					expv[d][f] = 9'(d * 37 + f * 11 + 5) & 9'((1 << tw(d, f)) - 1);
				end
		// illegal divider code must not land anywhere
		op(1, 4'h9, 3'h0, 9'h1FF);
		read_all();
	endtask

	task automatic t_nominal();
		logic [8:0] cnt [3] = '{9'd7, 9'd1, 9'd10};
		logic [2:0] fl [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
		for (int i = 0; i < 3; i++)
		begin
			op(1, 4'h1, 3'h7, cnt[i]);
			expv[1][0] = (cnt[i] + 9'd1) >> 1;
			expv[1][1] = cnt[i] - expv[1][0];
			expv[1][4] = {8'h00, cnt[i] == 9'd1};
			expv[1][5] = {8'h00, cnt[i][0]};
			op(0, 4'h1, 3'h7, 9'h000);
			check(got, cnt[i]);
			for (int j = 0; j < 4; j++)
			begin
				op(0, 4'h1, fl[j], 9'h000);
				check(got, expv[1][fl[j]]);
			end
		end
	endtask

	task automatic t_apply(input logic s, input logic quiet);
		@(posedge sys_clk);
		slow <= s;
		silent <= quiet;
		op(2, 4'h0, 3'h0, 9'h000);
		check({8'h00, scanDoneTimeout}, {8'h00, quiet});
		check(bitCount, 9'(CHAIN_LEN));
		check({8'h00, chain === want_chain()}, 9'h001);
	endtask

	task automatic t_drop();
		@(posedge sys_clk);
		applyStrobe <= 1'b1;
		@(posedge sys_clk);
		applyStrobe <= 1'b0;
		repeat (3) @(posedge sys_clk);
		// store issued while busy on purpose
		divSel <= 4'h3;
		fieldSel <= 3'h0;
		writeValue <= ~expv[3][0];
		storeStrobe <= 1'b1;
		@(posedge sys_clk);
		storeStrobe <= 1'b0;
		wait_idle();
		op(0, 4'h3, 3'h0, 9'h000);
		check(got, expv[3][0]);
	endtask

	// a strobe while the clock enable is low must not start anything
	task automatic t_freeze();
		@(posedge sys_clk);
		ce <= 1'b0;
		fetchStrobe <= 1'b1;
		@(posedge sys_clk);
		fetchStrobe <= 1'b0;
		@(posedge sys_clk);
		ce <= 1'b1;
		#1;
		check({8'h00, busy}, 9'h000);
	endtask

	task automatic t_reset_req();
		@(posedge sys_clk);
		pllResetReq <= 1'b1;
		@(posedge sys_clk);
		pllResetReq <= 1'b0;
		#1;
		check({7'h00, busy, pllAreset}, 9'h001);
	endtask

	initial
	begin
		{srst, ce} = 2'b11;
		{fetchStrobe, storeStrobe, applyStrobe, pllResetReq, silent, slow} = 6'h00;
		divSel = 4'h0;
		fieldSel = 3'h0;
		writeValue = 9'h000;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		check({5'h00, busy, pllAreset, pllScanClkEna, pllScanData}, 9'h000);
		t_store_all();
		t_nominal();
		t_apply(1'b0, 1'b0);
		t_apply(1'b1, 1'b0);
		read_all();
		t_drop();
		t_apply(1'b0, 1'b1);
		t_apply(1'b0, 1'b0);
		t_freeze();
		t_reset_req();
		wrap_up();
	end
endmodule
`default_nettype wire
